//--- rtl/dmx_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Column phase drives A11..A1; base row is A22,A20,A18,A16,A15..A9.
// - Next configurations put A17 on row bit 0, then A19 on bit 1.
// - Further configurations add A21 on row bit 2.
// - Further configurations add A23 on row bit 3.
// - Four meg four-way puts A24 on row bit 4, A23 on bit 3.
// - Control and floor register is 16 bits at port 6872H, read/write.
// - Bit 15 set advances the pointer after each page register access, except with map-enable 00.
// - Bits 14-13 place the upper frame block at C4000H..D0000H.
// - Bits 12, 9 and 8 are ignored on write and read zero.
// - Map-enable 00 disables all mapping and page register programming.
// - Map-enable 01 allows programming with no frame mapped.
// - Map-enable 10 maps upper frames and allows programming.
// - Map-enable 11 maps upper and lower frames and allows programming.
// - Map-enable 11 forces lower page registers 0..31 enabled as a block.
// - Bit 7 decides whether bits 6-0 act as the floor.
// - With floor enabled, memory above it leaves extended memory.

module dmx_ctrl (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_wdata,
  output logic [15:0] o_io_rdata,
  input wire logic i_page_reg_access,
  output logic o_ptr_advance,
  output logic o_page_prog_en,
  output logic o_upper_map_en,
  output logic o_lower_map_en,
  output logic o_lower_block_en,
  output logic [19:0] o_upper_frame_base,
  input wire logic [23:0] i_mem_addr,
  output logic o_floor_reserved,
  input wire logic [1:0] i_dram_size,
  input wire logic [1:0] i_interleave,
  input wire logic [24:1] i_cpu_addr,
  input wire logic i_col_phase,
  input wire logic i_refresh,
  input wire logic [10:0] i_refresh_row,
  output logic [10:0] o_dram_addr
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic auto_inc;
    logic [1:0] upper_frame_base;
    dmx_pkg::dmx_map_mode_t frame_map_enable;
    logic boundary_enable;
    logic [6:0] expanded_floor_addr;
    logic [15:0] rdata;
    logic ptr_advance;
    logic page_prog_en;
    logic upper_map_en;
    logic lower_map_en;
    logic [19:0] upper_base;
    logic floor_reserved;
  } dmx_ctrl_state_t;

  dmx_ctrl_state_t state_ff;
  dmx_ctrl_state_t nxt_state;

  function automatic logic [19:0] frame_base(input logic [1:0] loc);
    case (loc)
      2'b00: frame_base = dmx_pkg::UPPER_BASE_00;
      2'b01: frame_base = dmx_pkg::UPPER_BASE_01;
      2'b10: frame_base = dmx_pkg::UPPER_BASE_10;
      default: frame_base = dmx_pkg::UPPER_BASE_11;
    endcase
  endfunction : frame_base

  logic hit;
  logic [15:0] view;
  logic [24:0] floor_start;
  dmx_pkg::dmx_map_mode_t mode;

  always_comb begin
    nxt_state = state_ff;
    hit = (i_io_addr == dmx_pkg::CTRL_PORT);
    view = 16'h0000;
    view[dmx_pkg::INC_BIT] = state_ff.auto_inc;
    view[dmx_pkg::FRAME_LOC_HI:dmx_pkg::FRAME_LOC_LO] =
      state_ff.upper_frame_base;
    view[dmx_pkg::MAP_EN_HI:dmx_pkg::MAP_EN_LO] = state_ff.frame_map_enable;
    view[dmx_pkg::BOUND_EN_BIT] = state_ff.boundary_enable;
    view[dmx_pkg::FLOOR_HI:dmx_pkg::FLOOR_LO] = state_ff.expanded_floor_addr;
    // Unused bits 12, 9 and 8 are never stored, so they read as zero.
    if (hit && i_io_wr) begin
      nxt_state.auto_inc = i_io_wdata[dmx_pkg::INC_BIT];
      nxt_state.upper_frame_base =
        i_io_wdata[dmx_pkg::FRAME_LOC_HI:dmx_pkg::FRAME_LOC_LO];
      nxt_state.frame_map_enable = dmx_pkg::dmx_map_mode_t'(
        i_io_wdata[dmx_pkg::MAP_EN_HI:dmx_pkg::MAP_EN_LO]);
      nxt_state.boundary_enable = i_io_wdata[dmx_pkg::BOUND_EN_BIT];
      nxt_state.expanded_floor_addr =
        i_io_wdata[dmx_pkg::FLOOR_HI:dmx_pkg::FLOOR_LO];
    end
    if (hit && i_io_rd) begin
      nxt_state.rdata = view;
    end else begin
      nxt_state.rdata = 16'h0000;
    end
    mode = state_ff.frame_map_enable;
    case (mode)
      dmx_pkg::DMX_MAP_OFF: begin
        nxt_state.page_prog_en = 1'b0;
        nxt_state.upper_map_en = 1'b0;
        nxt_state.lower_map_en = 1'b0;
      end
      dmx_pkg::DMX_MAP_PROG: begin
        nxt_state.page_prog_en = 1'b1;
        nxt_state.upper_map_en = 1'b0;
        nxt_state.lower_map_en = 1'b0;
      end
      dmx_pkg::DMX_MAP_UPPER: begin
        nxt_state.page_prog_en = 1'b1;
        nxt_state.upper_map_en = 1'b1;
        nxt_state.lower_map_en = 1'b0;
      end
      dmx_pkg::DMX_MAP_BOTH: begin
        nxt_state.page_prog_en = 1'b1;
        nxt_state.upper_map_en = 1'b1;
        nxt_state.lower_map_en = 1'b1;
      end
      default: begin
        nxt_state.page_prog_en = 1'b0;
        nxt_state.upper_map_en = 1'b0;
        nxt_state.lower_map_en = 1'b0;
      end
    endcase
    // Accesses while programming is disabled never reach a page register,
    // so the pointer must not move for them either.
    nxt_state.ptr_advance = i_page_reg_access && state_ff.auto_inc &&
                            state_ff.page_prog_en;
    nxt_state.upper_base = frame_base(state_ff.upper_frame_base);
    // The stored value sits one unit below the real start.
    // A field of 7FH puts the start just past the 24-bit space; the extra
    // bit keeps it from wrapping to zero and reserving everything.
    floor_start = {({1'b0, state_ff.expanded_floor_addr} +
                    dmx_pkg::FLOOR_STEP), 17'h0_0000};
    nxt_state.floor_reserved =
      state_ff.boundary_enable &&
      ({1'b0, i_mem_addr} >= floor_start);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= '{auto_inc: dmx_pkg::RST_INC,
                    upper_frame_base: dmx_pkg::RST_FRAME_LOC,
                    frame_map_enable: dmx_pkg::DMX_MAP_OFF,
                    boundary_enable: dmx_pkg::RST_BOUND_EN,
                    expanded_floor_addr: dmx_pkg::RST_FLOOR,
                    rdata: 16'h0000,
                    ptr_advance: 1'b0,
                    page_prog_en: 1'b0,
                    upper_map_en: 1'b0,
                    lower_map_en: 1'b0,
                    upper_base: dmx_pkg::UPPER_BASE_00,
                    floor_reserved: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_io_rdata = state_ff.rdata;
  assign o_ptr_advance = state_ff.ptr_advance;
  assign o_page_prog_en = state_ff.page_prog_en;
  assign o_upper_map_en = state_ff.upper_map_en;
  assign o_lower_map_en = state_ff.lower_map_en;
  assign o_lower_block_en = state_ff.lower_map_en;
  assign o_upper_frame_base = state_ff.upper_base;
  assign o_floor_reserved = state_ff.floor_reserved;

  dmx_addr_mux u_mux (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_dram_size(i_dram_size),
    .i_interleave(i_interleave),
    .i_cpu_addr(i_cpu_addr),
    .i_col_phase(i_col_phase),
    .i_refresh(i_refresh),
    .i_refresh_row(i_refresh_row),
    .o_dram_addr(o_dram_addr)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_readback;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_io_wr && i_io_addr == 16'h6872) ##1
      (i_io_rd && !i_io_wr && i_io_addr == 16'h6872) |=>
        o_io_rdata == ($past(i_io_wdata, 2) & 16'hECFF);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Register read back differs.");

  property p_inc;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_page_reg_access && state_ff.auto_inc && state_ff.page_prog_en)
        |=> o_ptr_advance;
  endproperty
  a_inc: assert property (p_inc)
    else $error("Pointer did not advance.");

  property p_no_inc;
    @(posedge i_clk) disable iff (!i_reset_n)
      !state_ff.auto_inc |=> !o_ptr_advance;
  endproperty
  a_no_inc: assert property (p_no_inc)
    else $error("Pointer advanced with increment off.");

  property p_base;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff.upper_frame_base == 2'b11) |=>
        o_upper_frame_base == 20'hD_0000;
  endproperty
  a_base: assert property (p_base)
    else $error("Upper frame base wrong.");

  property p_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff.frame_map_enable == 2'b00) |=>
        !o_page_prog_en && !o_upper_map_en && !o_lower_map_en;
  endproperty
  a_off: assert property (p_off)
    else $error("Mapping active while disabled.");

  property p_prog;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff.frame_map_enable == 2'b01) |=>
        o_page_prog_en && !o_upper_map_en;
  endproperty
  a_prog: assert property (p_prog)
    else $error("Program-only mode wrong.");

  property p_both;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff.frame_map_enable == 2'b11) |=>
        o_upper_map_en && o_lower_map_en && o_lower_block_en;
  endproperty
  a_both: assert property (p_both)
    else $error("Full mapping not enabled.");

  property p_floor;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff.boundary_enable && state_ff.expanded_floor_addr == 7'h07 &&
       i_mem_addr == 24'h10_0000) |=> o_floor_reserved;
  endproperty
  a_floor: assert property (p_floor)
    else $error("Floor did not reserve memory.");

  property p_floor_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      !state_ff.boundary_enable |=> !o_floor_reserved;
  endproperty
  a_floor_off: assert property (p_floor_off)
    else $error("Floor active while disabled.");

endmodule : dmx_ctrl

`default_nettype wire

//--- rtl/dmx_pkg.sv
`default_nettype none

package dmx_pkg;

  // ****************************************************************
  // Register location and field layout
  // ****************************************************************
  localparam logic [15:0] CTRL_PORT = 16'h6872;
  localparam int INC_BIT = 15;
  localparam int FRAME_LOC_HI = 14;
  localparam int FRAME_LOC_LO = 13;
  localparam int MAP_EN_HI = 11;
  localparam int MAP_EN_LO = 10;
  localparam int BOUND_EN_BIT = 7;
  localparam int FLOOR_HI = 6;
  localparam int FLOOR_LO = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_INC = 1'b0;
  localparam logic [1:0] RST_FRAME_LOC = 2'h0;
  localparam logic [1:0] RST_MAP_EN = 2'h0;
  localparam logic RST_BOUND_EN = 1'b0;
  localparam logic [6:0] RST_FLOOR = 7'h00;
  localparam logic [10:0] RST_DRAM_ADDR = 11'h000;

  // ****************************************************************
  // Upper frame block start addresses
  // ****************************************************************
  localparam logic [19:0] UPPER_BASE_00 = 20'hC_4000;
  localparam logic [19:0] UPPER_BASE_01 = 20'hC_8000;
  localparam logic [19:0] UPPER_BASE_10 = 20'hC_C000;
  localparam logic [19:0] UPPER_BASE_11 = 20'hD_0000;

  // The floor field holds A23..A17 of a point one 128 Kbyte unit below.
  localparam int FLOOR_SHIFT = 17;
  localparam logic [7:0] FLOOR_STEP = 8'h01;

  typedef enum logic [1:0] {
    DMX_MAP_OFF = 2'b00,
    DMX_MAP_PROG = 2'b01,
    DMX_MAP_UPPER = 2'b10,
    DMX_MAP_BOTH = 2'b11
  } dmx_map_mode_t;

  typedef enum logic [1:0] {
    DMX_SZ_64K = 2'b00,
    DMX_SZ_256K = 2'b01,
    DMX_SZ_1M = 2'b10,
    DMX_SZ_4M = 2'b11
  } dmx_size_t;

  typedef enum logic [1:0] {
    DMX_IL_NONE = 2'b00,
    DMX_IL_2WAY = 2'b01,
    DMX_IL_4WAY = 2'b10,
    DMX_IL_RSVD = 2'b11
  } dmx_ilv_t;

endpackage : dmx_pkg

`default_nettype wire

//--- rtl/dmx_addr_mux.sv
`timescale 1ns/100ps
`default_nettype none

module dmx_addr_mux (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [1:0] i_dram_size,
  input wire logic [1:0] i_interleave,
  input wire logic [24:1] i_cpu_addr,
  input wire logic i_col_phase,
  input wire logic i_refresh,
  input wire logic [10:0] i_refresh_row,
  output logic [10:0] o_dram_addr
);

  typedef struct packed {
    logic [10:0] dram_addr;
  } dmx_mux_state_t;

  dmx_mux_state_t state_ff;
  dmx_mux_state_t nxt_state;

  // Each size step and each interleave step frees one more low row bit.
  function automatic logic [2:0] depth(input logic [1:0] sz,
                                       input logic [1:0] il);
    logic [1:0] ilc;
    ilc = (il == dmx_pkg::DMX_IL_RSVD) ? dmx_pkg::DMX_IL_4WAY : il;
    depth = {1'b0, sz} + {1'b0, ilc};
  endfunction : depth

  logic [2:0] lvl;
  logic [10:0] row;

  always_comb begin
    lvl = depth(i_dram_size, i_interleave);
    row = {i_cpu_addr[22], i_cpu_addr[20], i_cpu_addr[18], i_cpu_addr[16],
           i_cpu_addr[15:9]};
    if (lvl >= 3'd1) begin
      row[0] = i_cpu_addr[17];
    end
    if (lvl >= 3'd2) begin
      row[1] = i_cpu_addr[19];
    end
    if (lvl >= 3'd3) begin
      row[2] = i_cpu_addr[21];
    end
    if (lvl >= 3'd4) begin
      row[3] = i_cpu_addr[23];
    end
    if (lvl >= 3'd5) begin
      row[4] = i_cpu_addr[24];
    end
    nxt_state = state_ff;
    if (i_refresh) begin
      nxt_state.dram_addr = i_refresh_row;
    end else if (i_col_phase) begin
      nxt_state.dram_addr = i_cpu_addr[11:1];
    end else begin
      nxt_state.dram_addr = row;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= '{dram_addr: dmx_pkg::RST_DRAM_ADDR};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_dram_addr = state_ff.dram_addr;

  property p_refresh_row;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_refresh |=> o_dram_addr == $past(i_refresh_row);
  endproperty
  a_refresh_row: assert property (p_refresh_row)
    else $error("Refresh row not driven.");

  property p_col;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!i_refresh && i_col_phase) |=> o_dram_addr == $past(i_cpu_addr[11:1]);
  endproperty
  a_col: assert property (p_col)
    else $error("Column address wrong.");

  property p_row_top;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!i_refresh && !i_col_phase) |=>
        o_dram_addr[10:5] == {$past(i_cpu_addr[22]), $past(i_cpu_addr[20]),
                              $past(i_cpu_addr[18]), $past(i_cpu_addr[16]),
                              $past(i_cpu_addr[15:14])};
  endproperty
  a_row_top: assert property (p_row_top)
    else $error("Fixed row bits wrong.");

  property p_row_a17;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!i_refresh && !i_col_phase && i_dram_size == dmx_pkg::DMX_SZ_256K &&
       i_interleave == dmx_pkg::DMX_IL_NONE) |=>
        o_dram_addr[1:0] == {$past(i_cpu_addr[10]), $past(i_cpu_addr[17])};
  endproperty
  a_row_a17: assert property (p_row_a17)
    else $error("Row bit 0 not A17.");

  property p_row_a24;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!i_refresh && !i_col_phase && i_dram_size == dmx_pkg::DMX_SZ_4M &&
       i_interleave == dmx_pkg::DMX_IL_4WAY) |=>
        o_dram_addr[4:0] == {$past(i_cpu_addr[24]), $past(i_cpu_addr[23]),
                             $past(i_cpu_addr[21]), $past(i_cpu_addr[19]),
                             $past(i_cpu_addr[17])};
  endproperty
  a_row_a24: assert property (p_row_a24)
    else $error("Row bits for largest setup wrong.");

endmodule : dmx_addr_mux

`default_nettype wire

//--- bench/dmx_ptr_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Page register pointer seen from the far side of the control block
// ****************************************************************
// The pointer wraps after the last of the forty page registers so a
// runaway advance shows up as a wrong count rather than an overflow.
module dmx_ptr_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_advance,
  output logic [5:0] o_ptr
);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ptr <= 6'h00;
    end else if (i_advance) begin
      o_ptr <= (o_ptr == 6'h27) ? 6'h00 : o_ptr + 6'h01;
    end
  end
endmodule : dmx_ptr_model

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic page_acc = 1'b0;
  logic ptr_adv, prog_en, up_en, lo_en, blk_en, floor_res;
  logic [19:0] base;
  logic [23:0] mem_addr = 24'h00_0000;
  logic [1:0] size = 2'h0;
  logic [1:0] ilv = 2'h0;
  logic [24:1] cpu_addr = 24'h00_0000;
  logic col = 1'b0;
  logic refr = 1'b0;
  logic [10:0] refr_row = 11'h000;
  logic [10:0] dram;
  logic [5:0] ptr;
  logic [15:0] rd_val;
  logic [24:1] pat;
  logic [19:0] bases [4] = '{20'hC_4000, 20'hC_8000, 20'hC_C000, 20'hD_0000};
  int err_total = 0;
  int n_tests = 0;

  always #2.5 i_clk = ~i_clk;

  dmx_ctrl dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_io_addr(io_addr),
    .i_io_wr(io_wr), .i_io_rd(io_rd), .i_io_wdata(io_wdata),
    .o_io_rdata(io_rdata), .i_page_reg_access(page_acc),
    .o_ptr_advance(ptr_adv), .o_page_prog_en(prog_en),
    .o_upper_map_en(up_en), .o_lower_map_en(lo_en),
    .o_lower_block_en(blk_en), .o_upper_frame_base(base),
    .i_mem_addr(mem_addr), .o_floor_reserved(floor_res),
    .i_dram_size(size), .i_interleave(ilv), .i_cpu_addr(cpu_addr),
    .i_col_phase(col), .i_refresh(refr), .i_refresh_row(refr_row),
    .o_dram_addr(dram)
  );

  dmx_ptr_model ptr_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_advance(ptr_adv),
    .o_ptr(ptr)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic io_write(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge i_clk);
    io_wr = 1'b0;
  endtask : io_write

  task automatic io_read(input logic [15:0] a, output logic [15:0] d);
    @(negedge i_clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge i_clk);
    d = io_rdata;
    io_rd = 1'b0;
  endtask : io_read

  // Derived outputs trail the register by one more flop stage.
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask : settle

  task automatic pulses(input int n);
    @(negedge i_clk);
    page_acc = 1'b1;
    repeat (n) @(negedge i_clk);
    page_acc = 1'b0;
    settle();
  endtask : pulses

  function automatic logic [10:0] row_exp(input logic [24:1] a,
                                          input int lvl);
    logic [10:0] r;
    r = {a[22], a[20], a[18], a[16], a[15:9]};
    if (lvl >= 1) r[0] = a[17];
    if (lvl >= 2) r[1] = a[19];
    if (lvl >= 3) r[2] = a[21];
    if (lvl >= 4) r[3] = a[23];
    if (lvl >= 5) r[4] = a[24];
    return r;
  endfunction : row_exp

  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // The sequence needs well under a thousand cycles; this allows twenty.
  initial begin
    #100000;
    err_total++;
    $display("Watchdog expired at t=%0t", $time);
    end_of_test();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    io_read(16'h6872, rd_val);
    chk(rd_val, 24'h0);
    chk(base, 24'hC_4000);
    chk({prog_en, up_en, lo_en, blk_en}, 24'h0);
    io_write(16'h6872, 16'hFFFF);
    io_read(16'h6872, rd_val);
    chk(rd_val, 24'hECFF);
    io_read(16'h6873, rd_val);
    chk(rd_val, 24'h0);
    io_write(16'h6874, 16'h0000);
    io_read(16'h6872, rd_val);
    chk(rd_val, 24'hECFF);
    // Write followed at once by a read of the same port.
    @(negedge i_clk);
    io_addr = 16'h6872;
    io_wdata = 16'h3D85;
    io_wr = 1'b1;
    @(negedge i_clk);
    io_wr = 1'b0;
    io_rd = 1'b1;
    @(negedge i_clk);
    rd_val = io_rdata;
    io_rd = 1'b0;
    chk(rd_val, 24'h2C85);
    for (int k = 0; k < 4; k++) begin
      io_write(16'h6872, {1'b0, k[1:0], 13'h0000});
      settle();
      chk(base, bases[k]);
    end
    for (int m = 0; m < 4; m++) begin
      io_write(16'h6872, {4'h0, m[1:0], 10'h000});
      settle();
      chk({prog_en, up_en, lo_en, blk_en},
          {20'h0, m != 0, m[1], m == 3, m == 3});
    end
    io_write(16'h6872, 16'h8400);
    settle();
    pulses(2);
    chk(ptr, 24'h2);
    io_write(16'h6872, 16'h0400);
    settle();
    pulses(1);
    chk(ptr, 24'h2);
    io_write(16'h6872, 16'h8000);
    settle();
    pulses(1);
    chk(ptr, 24'h2);
    io_write(16'h6872, 16'h0087);
    mem_addr = 24'h0F_FFFF;
    settle();
    chk(floor_res, 24'h0);
    mem_addr = 24'h10_0000;
    settle();
    chk(floor_res, 24'h1);
    io_write(16'h6872, 16'h0007);
    settle();
    chk(floor_res, 24'h0);
    io_write(16'h6872, 16'h00FF);
    mem_addr = 24'hFF_FFFF;
    settle();
    chk(floor_res, 24'h0);
    for (int p = 0; p < 2; p++) begin
      pat = p ? ~24'h5A_93C4 : 24'h5A_93C4;
      for (int s = 0; s < 4; s++) begin
        for (int v = 0; v < 4; v++) begin
          @(negedge i_clk);
          cpu_addr = pat;
          size = s[1:0];
          ilv = v[1:0];
          col = 1'b0;
          @(negedge i_clk);
          chk(dram,
              row_exp(pat, s + ((v == 3) ? 2 : v)));
        end
      end
      col = 1'b1;
      @(negedge i_clk);
      chk(dram, pat[11:1]);
      refr = 1'b1;
      refr_row = p ? 11'h25C : 11'h5A3;
      @(negedge i_clk);
      chk(dram, refr_row);
      refr = 1'b0;
    end
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
